/* common/cpd_pkg.sv */
// constants and types of the cluster power domain control block
package cpd_pkg;
    // register byte offsets
    localparam logic [15:0] OFF_STEP = 16'h0008;
    localparam logic [15:0] OFF_SETTLE = 16'h0010;
    localparam logic [15:0] OFF_ROCC = 16'h0040;
    localparam logic [15:0] OFF_RUN = 16'h0080;
    localparam logic [15:0] OFF_STOP = 16'h0084;
    localparam logic [15:0] OFF_RUNNING = 16'h0088;
    localparam logic [15:0] OFF_SEQ_STAT = 16'h008C;
    localparam logic [15:0] OFF_RAM_BASE = 16'h1050;
    localparam logic [15:0] OFF_RAM_STRIDE = 16'h0100;
    // field layout
    localparam int CNT_W = 10;
    localparam int CAUSE_LSB = 16;
    localparam int LS_INHIBIT_BIT = 31;
    localparam int LS_DLY_LSB = 16;
    localparam int PO_INHIBIT_BIT = 15;
    localparam int PO_DLY_LSB = 0;
    localparam int DLY_W = 8;
    localparam logic [31:0] RAM_CFG_MASK = 32'h80FF_80FF;
    // reset values and minimum delay
    localparam logic [CNT_W-1:0] STEP_RST = 10'h002;
    localparam logic [CNT_W-1:0] SETTLE_RST = 10'h010;
    localparam logic [31:0] RAM_CFG_RST = 32'h0001_0001;
    localparam logic [DLY_W-1:0] DLY_MIN = 8'h01;
    // domain power state as reported by each domain
    localparam logic [1:0] PWR_OPER = 2'h0;
    localparam logic [1:0] PWR_CLK_STOP = 2'h1;
    localparam logic [1:0] PWR_DOWN = 2'h2;
    // reset origin codes
    localparam logic [1:0] CAUSE_COLD = 2'h0;
    localparam logic [1:0] CAUSE_WARM = 2'h1;
    localparam logic [1:0] CAUSE_WDOG = 2'h2;
    typedef enum logic [2:0] {
        SQ_IDLE, SQ_SETTLE, SQ_STEP0, SQ_STEP1, SQ_STEP2, SQ_HOLD, SQ_RUN
    } cpd_seq_e;
    typedef enum logic [1:0] {RS_ON, RS_SLEEP, RS_SHUT, RS_WAKE} cpd_ram_e;
endpackage

/* common/cpd_ram_if.sv */
// link between the controller and one domain's local RAM sleep logic
`timescale 1ns/1ps
`default_nettype none
interface cpd_ram_if;
    logic [31:0] cfg;
    logic [1:0] pwr;
    logic sleep;
    logic shut;
    logic hold;
    modport ctl (input cfg, input pwr, output sleep, output shut, output hold);
    modport top (output cfg, output pwr, input sleep, input shut, input hold);
endinterface
`default_nettype wire

/* rtl/cpd_ctrl.sv */
// cluster power domain control: reset record, thread run control, RAM sleep, sequencer
`timescale 1ns/1ps
`default_nettype none
module cpd_ctrl #(
    parameter int NUM_DOMAINS = 2,
    parameter int NUM_DEVS = 4,
    parameter int NUM_THREADS = 2
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic [15:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // reset detection
    input wire logic [NUM_DEVS-1:0] dev_rst_i,
    input wire logic [1:0] rst_cause_i,
    // thread control
    input wire logic core_rst_i,
    input wire logic hw_run_clr_i,
    input wire logic dbg_run_clr_i,
    output logic [NUM_THREADS-1:0] thread_running_o,
    // domain sequencer
    input wire logic seq_start_i,
    input wire logic seq_stop_i,
    output logic supply_switch_on_o,
    output logic domain_up_o,
    // local RAMs
    input wire logic [2*NUM_DOMAINS-1:0] dom_pwr_state_i,
    output logic [NUM_DOMAINS-1:0] ram_sleep_o,
    output logic [NUM_DOMAINS-1:0] ram_shut_o
);
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        addr_hit = a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire setup = psel_i & ~penable_i;
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire hit_step = addr_hit(paddr_i, cpd_pkg::OFF_STEP);
    wire hit_settle = addr_hit(paddr_i, cpd_pkg::OFF_SETTLE);
    wire hit_rocc = addr_hit(paddr_i, cpd_pkg::OFF_ROCC);
    wire hit_run = addr_hit(paddr_i, cpd_pkg::OFF_RUN);
    wire hit_stop = addr_hit(paddr_i, cpd_pkg::OFF_STOP);
    wire hit_running = addr_hit(paddr_i, cpd_pkg::OFF_RUNNING);
    wire hit_stat = addr_hit(paddr_i, cpd_pkg::OFF_SEQ_STAT);
    logic [NUM_DOMAINS-1:0] hit_ram;
    logic [NUM_DOMAINS-1:0] ram_hold;
    logic [31:0] ram_cfg [NUM_DOMAINS];
    wire hit_any = hit_step | hit_settle | hit_rocc | hit_run | hit_stop | hit_running
        | hit_stat | (|hit_ram);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [cpd_pkg::CNT_W-1:0] step_cnt_cfg;
    logic [cpd_pkg::CNT_W-1:0] settle_cfg;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt_cfg <= cpd_pkg::STEP_RST;
            settle_cfg <= cpd_pkg::SETTLE_RST;
        end else begin
            if (wr && hit_step) begin
                step_cnt_cfg <= pwdata_i[cpd_pkg::CNT_W-1:0];
            end
            if (wr && hit_settle) begin
                settle_cfg <= pwdata_i[cpd_pkg::CNT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-domain RAM sleep registers and controllers
    genvar g;
    generate
        for (g = 0; g < NUM_DOMAINS; g++) begin : g_dom
            cpd_ram_if u_if ();
            assign hit_ram[g] = addr_hit(paddr_i, 16'(cpd_pkg::OFF_RAM_BASE
                + cpd_pkg::OFF_RAM_STRIDE * g));
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    ram_cfg[g] <= cpd_pkg::RAM_CFG_RST;
                end else if (wr && hit_ram[g]) begin
                    ram_cfg[g] <= pwdata_i & cpd_pkg::RAM_CFG_MASK;
                end
            end
            assign u_if.cfg = ram_cfg[g];
            assign u_if.pwr = dom_pwr_state_i[2*g +: 2];
            assign ram_hold[g] = u_if.hold;
            assign ram_sleep_o[g] = u_if.sleep;
            assign ram_shut_o[g] = u_if.shut;
            cpd_ram_sleep u_ram (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .rif(u_if.ctl)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // reset detection
    logic [NUM_DEVS-1:0] rst_seen;
    logic [1:0] rst_cause;
    logic cause_taken;
    // only bits already returned by this read are cleared, so a reset that
    // lands between setup and access is kept; a new set wins over the clear
    wire [NUM_DEVS-1:0] rocc_clr = (rd && hit_rocc) ? prdata_o[NUM_DEVS-1:0] : '0;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_seen <= NUM_DEVS'(1);
            rst_cause <= cpd_pkg::CAUSE_COLD;
            cause_taken <= 1'b0;
        end else begin
            rst_seen <= (rst_seen & ~rocc_clr) | dev_rst_i;
            if (!cause_taken) begin
                rst_cause <= rst_cause_i;
                cause_taken <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // thread run and suspend
    logic [NUM_THREADS-1:0] run_req;
    logic [NUM_THREADS-1:0] running;
    wire run_clr = core_rst_i | hw_run_clr_i | dbg_run_clr_i;
    // a run bit for a thread that already runs is dropped at once
    wire [NUM_THREADS-1:0] run_set = (wr && hit_run)
        ? pwdata_i[NUM_THREADS-1:0] & ~running : '0;
    wire [NUM_THREADS-1:0] stop_set = (wr && hit_stop)
        ? pwdata_i[NUM_THREADS-1:0] & running : '0;
    wire [NUM_THREADS-1:0] run_take = run_req & ~running;
    wire [NUM_THREADS-1:0] next_run_req = run_clr ? '0 : run_set;
    wire [NUM_THREADS-1:0] next_running = core_rst_i ? '0
        : (running | run_take) & ~stop_set;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_req <= '0;
            running <= '0;
            thread_running_o <= '0;
        end else begin
            run_req <= next_run_req;
            running <= next_running;
            thread_running_o <= next_running;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // domain sequencer
    cpd_pkg::cpd_seq_e sq;
    cpd_pkg::cpd_seq_e next_sq;
    logic [cpd_pkg::CNT_W-1:0] cnt;
    logic [cpd_pkg::CNT_W-1:0] next_cnt;
    wire cnt_zero = cnt == '0;
    wire [cpd_pkg::CNT_W-1:0] cnt_dec = cnt - 10'h001;

    always_comb begin
        next_sq = sq;
        next_cnt = cnt;
        case (sq)
            cpd_pkg::SQ_IDLE: begin
                if (seq_start_i) begin
                    next_sq = cpd_pkg::SQ_SETTLE;
                    next_cnt = settle_cfg;
                end
            end
            cpd_pkg::SQ_SETTLE: begin
                if (cnt_zero) begin
                    next_sq = cpd_pkg::SQ_STEP0;
                    next_cnt = step_cnt_cfg;
                end else begin
                    next_cnt = cnt_dec;
                end
            end
            cpd_pkg::SQ_STEP0, cpd_pkg::SQ_STEP1, cpd_pkg::SQ_STEP2: begin
                if (cnt_zero) begin
                    next_sq = cpd_pkg::cpd_seq_e'(sq + 3'h1);
                    next_cnt = step_cnt_cfg;
                end else begin
                    next_cnt = cnt_dec;
                end
            end
            cpd_pkg::SQ_HOLD: begin
                // RAMs waking in any domain keep the move to run back
                if (ram_hold == '0) begin
                    next_sq = cpd_pkg::SQ_RUN;
                end
            end
            cpd_pkg::SQ_RUN: next_sq = cpd_pkg::SQ_RUN;
            default: next_sq = cpd_pkg::SQ_IDLE;
        endcase
        if (seq_stop_i) begin
            next_sq = cpd_pkg::SQ_IDLE;
            next_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sq <= cpd_pkg::SQ_IDLE;
            cnt <= '0;
            supply_switch_on_o <= 1'b0;
            domain_up_o <= 1'b0;
        end else begin
            sq <= next_sq;
            cnt <= next_cnt;
            supply_switch_on_o <= next_sq != cpd_pkg::SQ_IDLE;
            domain_up_o <= next_sq == cpd_pkg::SQ_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and bus answer
    logic [31:0] rd_ram;
    always_comb begin
        rd_ram = '0;
        for (int d = 0; d < NUM_DOMAINS; d++) begin
            rd_ram = rd_ram | (hit_ram[d] ? ram_cfg[d] : '0);
        end
    end
    // run and stop read as zero; writes to read-only words fall through
    wire [31:0] rd_data = hit_step ? 32'(step_cnt_cfg)
        : hit_settle ? 32'(settle_cfg)
        : hit_rocc ? (32'(rst_seen) | (32'(rst_cause) << cpd_pkg::CAUSE_LSB))
        : hit_running ? 32'(running)
        : hit_stat ? 32'(sq)
        : rd_ram;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            if (setup) begin
                prdata_o <= pwrite_i ? '0 : rd_data;
                pslverr_o <= ~hit_any;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_settle_done;
        sq == cpd_pkg::SQ_SETTLE && cnt_zero && !seq_stop_i;
    endsequence
    sequence s_step0_entry;
        sq == cpd_pkg::SQ_STEP0 && cnt == $past(step_cnt_cfg);
    endsequence
    a_dev_rst_seen: assert property (dev_rst_i[0] |=> rst_seen[0])
        else $error("device reset not recorded");
    a_run_starts: assert property (wr && hit_run && pwdata_i[0] && !running[0] && !run_clr
        ##1 !core_rst_i && !stop_set[0] |=> running[0])
        else $error("run request did not start thread");
    a_run_ignored: assert property (wr && hit_run && running[0] |=> !run_req[0])
        else $error("run request on running thread kept");
    a_core_rst_clr: assert property (core_rst_i |=> run_req == '0 && running == '0)
        else $error("core reset did not clear run state");
    a_stop_suspends: assert property (wr && hit_stop && pwdata_i[0] && running[0]
        |=> !running[0] && !thread_running_o[0])
        else $error("stop request did not suspend thread");
    a_stop_zero_idle: assert property (wr && hit_stop && pwdata_i[NUM_THREADS-1:0] == '0
        && run_req == '0 && !core_rst_i |=> $stable(running))
        else $error("zero stop write changed a thread");
    a_settle_then_step: assert property (s_settle_done |=> s_step0_entry)
        else $error("sequencer did not start after settle");
    a_settle_waits: assert property (sq == cpd_pkg::SQ_SETTLE && !cnt_zero && !seq_stop_i
        |=> sq == cpd_pkg::SQ_SETTLE && cnt == $past(cnt) - 10'h001)
        else $error("sequencer left settle early");
    a_step_length: assert property (sq == cpd_pkg::SQ_STEP1 && !cnt_zero && !seq_stop_i
        |=> sq == cpd_pkg::SQ_STEP1)
        else $error("sequencer state ended early");
    a_ro_write_kept: assert property (wr && (hit_rocc || hit_running) && dev_rst_i == '0
        && !run_clr && run_req == '0 |=> $stable(rst_seen) && $stable(running))
        else $error("write to read-only word changed state");
endmodule
`default_nettype wire

/* rtl/cpd_ram_sleep.sv */
// local RAM sleep and shutdown control with wake-up hold for one domain
`timescale 1ns/1ps
`default_nettype none
module cpd_ram_sleep (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // controller side
    cpd_ram_if.ctl rif
);
    cpd_pkg::cpd_ram_e state;
    cpd_pkg::cpd_ram_e next_state;
    logic [cpd_pkg::DLY_W-1:0] cnt;
    logic [cpd_pkg::DLY_W-1:0] next_cnt;
    wire ls_ok = ~rif.cfg[cpd_pkg::LS_INHIBIT_BIT];
    wire po_ok = ~rif.cfg[cpd_pkg::PO_INHIBIT_BIT];
    wire [cpd_pkg::DLY_W-1:0] ls_raw = rif.cfg[cpd_pkg::LS_DLY_LSB +: cpd_pkg::DLY_W];
    wire [cpd_pkg::DLY_W-1:0] po_raw = rif.cfg[cpd_pkg::PO_DLY_LSB +: cpd_pkg::DLY_W];
    // a zero delay field still gives the RAMs one clock
    wire [cpd_pkg::DLY_W-1:0] ls_dly = (ls_raw == '0) ? cpd_pkg::DLY_MIN : ls_raw;
    wire [cpd_pkg::DLY_W-1:0] po_dly = (po_raw == '0) ? cpd_pkg::DLY_MIN : po_raw;
    wire is_oper = rif.pwr == cpd_pkg::PWR_OPER;
    wire is_stop = rif.pwr == cpd_pkg::PWR_CLK_STOP;
    wire is_down = rif.pwr == cpd_pkg::PWR_DOWN;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            cpd_pkg::RS_ON: begin
                if (is_stop && ls_ok) begin
                    next_state = cpd_pkg::RS_SLEEP;
                end else if (is_down && po_ok) begin
                    next_state = cpd_pkg::RS_SHUT;
                end
            end
            cpd_pkg::RS_SLEEP: begin
                if (is_down && po_ok) begin
                    next_state = cpd_pkg::RS_SHUT;
                end else if (is_oper) begin
                    next_state = cpd_pkg::RS_WAKE;
                    next_cnt = ls_dly;
                end
            end
            cpd_pkg::RS_SHUT: begin
                // clock-stopped alone does not lift shutdown
                if (is_oper) begin
                    next_state = cpd_pkg::RS_WAKE;
                    next_cnt = po_dly;
                end
            end
            cpd_pkg::RS_WAKE: begin
                if (cnt == cpd_pkg::DLY_MIN) begin
                    next_state = cpd_pkg::RS_ON;
                end else begin
                    next_cnt = cnt - cpd_pkg::DLY_MIN;
                end
            end
            default: next_state = cpd_pkg::RS_ON;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= cpd_pkg::RS_ON;
            cnt <= '0;
            rif.sleep <= 1'b0;
            rif.shut <= 1'b0;
            rif.hold <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            rif.sleep <= next_state == cpd_pkg::RS_SLEEP;
            rif.shut <= next_state == cpd_pkg::RS_SHUT;
            rif.hold <= next_state == cpd_pkg::RS_WAKE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_shut_stays_shut: assert property (state == cpd_pkg::RS_SHUT && is_stop |=> rif.shut)
        else $error("shutdown left on clock-stopped");
    a_sleep_wake_hold: assert property (state == cpd_pkg::RS_SLEEP && is_oper && !(is_down)
        |=> rif.hold && cnt == $past(ls_dly))
        else $error("deep sleep wake hold not applied");
    a_sleep_enter: assert property (state == cpd_pkg::RS_ON && is_stop && ls_ok
        |=> rif.sleep)
        else $error("RAMs did not enter deep sleep");
endmodule
`default_nettype wire

/* verification/cpd_dom_model.sv */
// behavioural model of the power domains that report their state to the controller
`timescale 1ns/1ps
`default_nettype none
module cpd_dom_model #(
    parameter int ND = 2
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // wanted state per domain and response latency
    input wire logic [2*ND-1:0] tgt_i,
    input wire logic [7:0] lat_i,
    // reported power state per domain
    output logic [2*ND-1:0] pwr_o
);
    logic [7:0] wait_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // each domain reports its own state; any state may follow any other, so
    // powered-down can go to clock-stopped without passing operational
    // a non-zero latency models a slow domain that lags the request
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_o <= '0;
            wait_cnt <= 8'h00;
        end else if (pwr_o == tgt_i) begin
            wait_cnt <= 8'h00;
        end else if (wait_cnt >= lat_i) begin
            pwr_o <= tgt_i;
            wait_cnt <= 8'h00;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking testbench of the cluster power domain control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, switch_on, dom_up;
    logic [3:0] dev_rst = 4'h0;
    logic [1:0] cause = 2'h0;
    logic core_rst = 1'b0, hw_clr = 1'b0, dbg_clr = 1'b0, seq_start = 1'b0, seq_stop = 1'b0;
    logic [1:0] running, sleep, shut;
    logic [3:0] tgt = 4'h0;
    logic [3:0] pwr;
    logic [7:0] lat = 8'h00;
    logic [1:0] codes [3] = '{cpd_pkg::CAUSE_COLD, cpd_pkg::CAUSE_WARM, cpd_pkg::CAUSE_WDOG};
    int sn [3] = '{16, 5, 0};
    int ss [3] = '{2, 1, 0};
    int num_errors = 0;
    int checked = 0;
    int n;

    always #25 core_clk = ~core_clk;

    cpd_ctrl #(.NUM_DOMAINS(2), .NUM_DEVS(4), .NUM_THREADS(2)) i_dut (
        .core_clk_i(core_clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .dev_rst_i(dev_rst), .rst_cause_i(cause),
        .core_rst_i(core_rst), .hw_run_clr_i(hw_clr), .dbg_run_clr_i(dbg_clr),
        .thread_running_o(running), .seq_start_i(seq_start), .seq_stop_i(seq_stop),
        .supply_switch_on_o(switch_on), .domain_up_o(dom_up), .dom_pwr_state_i(pwr),
        .ram_sleep_o(sleep), .ram_shut_o(shut));

    cpd_dom_model #(.ND(2)) i_dom (
        .core_clk_i(core_clk), .rst_i(rst), .tgt_i(tgt), .lat_i(lat), .pwr_o(pwr));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // every transfer starts on a fresh edge, so a release and the next setup never collide
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int w;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        w = 0;
        // only the watchdog ends this wait; the slave answers with no wait state
        do begin
            @(posedge core_clk);
            w++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(w, 1);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, q, er);
        chk(er, e);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic e);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h0000_0000, q, er);
        chk(er, e);
        if (e == 1'b0) chk(q, d);
    endtask

    task automatic thr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] exp);
        wr(a, d, 1'b0);
        tick(2);
        chk(running, exp);
    endtask

    task automatic do_reset(input logic [1:0] c);
        @(posedge core_clk);
        rst <= 1'b1;
        cause <= c;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    // counts edges from the one that takes the start pulse to the first one with the domain up
    task automatic seq_run(output int k);
        @(posedge core_clk);
        seq_start <= 1'b1;
        @(posedge core_clk);
        seq_start <= 1'b0;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
            #1;
            if (k == 1) chk({switch_on, dom_up}, 2'b10);
        end while (dom_up !== 1'b1 && k < 1000);
        @(posedge core_clk);
        seq_stop <= 1'b1;
        @(posedge core_clk);
        seq_stop <= 1'b0;
        #1;
        chk({switch_on, dom_up}, 2'b00);
    endtask

    task automatic ram_step(input logic [3:0] t, input logic [3:0] exp);
        int w;
        @(posedge core_clk);
        tgt <= t;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
        end while (pwr !== t && w < 300);
        tick(1);
        chk({sleep, shut}, exp);
    endtask

    // the sequencer must sit in its hold state until the RAM wake-up time is over
    task automatic wake_run(input int lo, input int hi);
        @(posedge core_clk);
        tgt <= 4'h0;
        do @(posedge core_clk); while (pwr !== 4'h0);
        seq_run(n);
        chk(n >= lo && n <= hi, 1'b1);
    endtask

    task automatic print_verdict;
        $display("Comparisons: %0d, mismatches: %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int c = 0; c < 3; c++) begin
            do_reset(codes[c]);
            rd(cpd_pkg::OFF_ROCC, {14'h0, codes[c], 16'h0001}, 1'b0);
            rd(cpd_pkg::OFF_ROCC, {14'h0, codes[c], 16'h0000}, 1'b0);
        end
        rd(cpd_pkg::OFF_STEP, 32'h0000_0002, 1'b0);
        rd(cpd_pkg::OFF_SEQ_STAT, 32'h0000_0000, 1'b0);
        rd(cpd_pkg::OFF_SETTLE, {22'h0, cpd_pkg::SETTLE_RST}, 1'b0);
        rd(cpd_pkg::OFF_RAM_BASE, cpd_pkg::RAM_CFG_RST, 1'b0);
        rd(16'h0100, 32'h0000_0000, 1'b1);
        wr(16'h0104, 32'hFFFF_FFFF, 1'b1);
        @(posedge core_clk);
        dev_rst <= 4'h4;
        @(posedge core_clk);
        dev_rst <= 4'h0;
        wr(cpd_pkg::OFF_ROCC, 32'hFFFF_FFFF, 1'b0);
        rd(cpd_pkg::OFF_ROCC, {14'h0, cpd_pkg::CAUSE_WDOG, 16'h0004}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            if (i > 0) wr(cpd_pkg::OFF_SETTLE, sn[i], 1'b0);
            if (i > 0) wr(cpd_pkg::OFF_STEP, ss[i], 1'b0);
            seq_run(n);
            chk(n, sn[i] + 3 * ss[i] + 5);
        end
        thr(cpd_pkg::OFF_RUN, 32'h1, 2'b01);
        rd(cpd_pkg::OFF_RUNNING, 32'h1, 1'b0);
        thr(cpd_pkg::OFF_RUN, 32'h1, 2'b01);
        thr(cpd_pkg::OFF_STOP, 32'h0, 2'b01);
        thr(cpd_pkg::OFF_STOP, 32'h2, 2'b01);
        thr(cpd_pkg::OFF_RUNNING, 32'h0, 2'b01);
        thr(cpd_pkg::OFF_STOP, 32'h1, 2'b00);
        thr(cpd_pkg::OFF_RUN, 32'h3, 2'b11);
        rd(cpd_pkg::OFF_RUN, 32'h0, 1'b0);
        @(posedge core_clk);
        core_rst <= 1'b1;
        @(posedge core_clk);
        core_rst <= 1'b0;
        tick(1);
        chk(running, 2'b00);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            {dbg_clr, hw_clr} <= 2'(i + 1);
            thr(cpd_pkg::OFF_RUN, 32'h1, 2'b00);
            @(posedge core_clk);
            {dbg_clr, hw_clr} <= 2'b00;
        end
        thr(cpd_pkg::OFF_RUN, 32'h2, 2'b10);
        wr(cpd_pkg::OFF_RAM_BASE, 32'h0040_0030, 1'b0);
        wr(cpd_pkg::OFF_RAM_BASE + cpd_pkg::OFF_RAM_STRIDE, 32'hFFFF_FFFF, 1'b0);
        rd(cpd_pkg::OFF_RAM_BASE + cpd_pkg::OFF_RAM_STRIDE, cpd_pkg::RAM_CFG_MASK, 1'b0);
        @(posedge core_clk);
        lat <= 8'h03;
        ram_step(4'h5, 4'h4);
        ram_step(4'hA, 4'h1);
        ram_step(4'h5, 4'h1);
        wake_run(42, 54);
        ram_step(4'h5, 4'h4);
        wake_run(58, 70);
        print_verdict;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #200000;
        num_errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        print_verdict;
    end
endmodule
`default_nettype wire
